// ===== hw/plgs_regs.sv
/*
 * Lock-detect, output-pin, slip-prevention and status register bank.
 * Assumes a decoded register port (write strobe, read strobe, address, data) from the
 * serial shifter in the core clock domain, and asynchronous analog signals at the pins.
 */
`timescale 1ns/1ps
module plgs_regs
	import plgs_pkg::*;
(
	// Clock, reset, enable.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// Register port from the serial shifter.
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [5:0]  i_addr,
	input  wire logic [23:0] i_wdata,
	input  wire logic        i_rd_busy,
	input  wire logic        i_rd_bit,
	output logic [23:0]      o_rdata,
	// Serial data output pin.
	output logic             o_sdo,
	// Analog and core signals to route or report.
	input  wire logic        i_ref_tick,
	input  wire logic        i_in_phase,
	input  wire logic        i_pfd_up,
	input  wire logic        i_detector_down_pulse,
	input  wire logic        i_sat_ref,
	input  wire logic        i_sat_div,
	input  wire logic        i_gain_hold,
	input  wire logic        i_aux_ref,
	input  wire logic        i_aux_sine,
	input  wire logic        i_synced_fraction_strobe,
	input  wire logic [3:1]  i_quantized_osc_phase,
	input  wire logic        i_aux_clk,
	input  wire logic        i_ring_test,
	input  wire logic        i_modulator_clock,
	input  wire logic        i_sweep_busy,
	input  wire logic [2:0]  i_quant_out,
	input  wire logic [3:1]  i_mod_overflow,
	input  wire logic [11:0] i_temp_deci,
	input  wire logic        i_slip_reset_auto,
	// General-purpose output pins.
	output logic             o_gp_out_pin_a,
	output logic             o_gp_out_pin_b,
	output logic             o_gp_out_pin_c,
	output logic             o_gp_out_pin_a_oe,
	output logic             o_gp_out_pin_b_oe,
	output logic             o_gp_out_pin_c_oe,
	// Detector controls.
	output logic [3:0]       o_slip_correction_step,
	output logic             o_slip_prevention_en,
	output logic             o_detector_reset_n,
	output logic             o_temp_sensor_en
);
	localparam int NSYNC = 18;

	typedef struct packed {
		logic [LCK_WIDTH-1:0]  lock_cfg;
		logic [GPO_WIDTH-1:0]  gpo_ctrl;
		logic [SLP_WIDTH-1:0]  slip_ctrl;
		logic                  temp_en;
		logic [NSYNC-1:0]      meta;
		logic [NSYNC-1:0]      sync;
		logic [23:0]           rdata;
		logic                  sdo;
		logic [2:0]            gp;
		logic [2:0]            oe;
		logic [3:0]            step;
		logic                  slip_en;
		logic                  det_rst_n;
	} plgs_bank_t;
	plgs_bank_t s_q, s_d;

	logic [NSYNC-1:0] pins;
	logic [6:0]       temp_code;
	logic             locked_flag;
	logic             sweep_active_flag;
	logic [3:1]       modulator_overflow_flags;
	logic [2:0]       route;
	logic [3:0]       gpo_sel;
	plgs_lock_if      lk ();

	assign pins = {i_ref_tick, i_in_phase, i_pfd_up, i_detector_down_pulse, i_sat_ref,
		i_sat_div, i_gain_hold, i_aux_ref, i_aux_sine, i_synced_fraction_strobe,
		i_quantized_osc_phase, i_aux_clk, i_ring_test, i_modulator_clock, i_sweep_busy,
		i_mod_overflow[1]};

	// The pin signals pass two flops (meta, sync) before anything looks at them.
	assign lk.ref_tick   = s_q.sync[17];
	assign lk.in_phase   = s_q.sync[16];
	assign lk.threshold  = s_q.lock_cfg[LCK_THR_MSB:0];
	assign lk.asym_en    = s_q.lock_cfg[LCK_ASYM];
	assign lk.asym_up    = s_q.lock_cfg[LCK_ASYM_UP];
	assign lk.ring_sel   = s_q.lock_cfg[LCK_RING];
	assign lk.ring_speed = s_q.lock_cfg[LCK_RSPD_LO +: 2];
	assign lk.duration   = s_q.lock_cfg[LCK_DUR_LO +: 2];

	assign locked_flag              = lk.locked;
	assign sweep_active_flag        = s_q.sync[1];
	// Overflow bits 3:2 come from the same core domain as bit 1's synchroniser.
	assign modulator_overflow_flags = {i_mod_overflow[3:2], s_q.sync[0]};
	assign gpo_sel                  = s_q.gpo_ctrl[GPO_SEL_LO +: 4];

	plgs_lock_det u_det (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.lk      (lk)
	);

	plgs_temp_conv u_temp (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_ce        (i_ce),
		.i_en        (s_q.temp_en),
		.i_deci_offs (i_temp_deci),
		.o_code      (temp_code)
	);

	always_comb
	begin
		route = 3'h0;
		case (gpo_sel)
			SEL_STATIC: route = s_q.gpo_ctrl[GPO_DAT_LO +: 3];
			SEL_PFD:    route = {s_q.sync[15], s_q.sync[14], lk.window};
			SEL_SAT:    route = {s_q.sync[13], s_q.sync[12], s_q.sync[11]};
			SEL_XREF:   route = {s_q.sync[10], s_q.sync[9], s_q.sync[8]};
			SEL_PHASE:  route = {s_q.sync[5], s_q.sync[6], s_q.sync[7]};
			SEL_CLKS:   route = {s_q.sync[4], s_q.sync[3], s_q.sync[2]};
			SEL_SWEEP:  route = {1'b0, sweep_active_flag, 1'b0};
			SEL_QUANT:  route = i_quant_out;
			default:    route = 3'h0;
		endcase
	end

	always_comb
	begin
		s_d      = s_q;
		s_d.meta = pins;
		s_d.sync = s_q.meta;
		// Reserved addresses fall through and keep no state.
		if (i_wr)
		begin
			if (i_addr == ADDR_LOCK_CFG)
				s_d.lock_cfg = i_wdata[LCK_WIDTH-1:0];
			else if (i_addr == ADDR_GPO_CTRL)
				s_d.gpo_ctrl = i_wdata[GPO_WIDTH-1:0];
			else if (i_addr == ADDR_SLIP_CTRL)
				s_d.slip_ctrl = i_wdata[SLP_WIDTH-1:0];
			else if (i_addr == ADDR_TEMP_EN)
				s_d.temp_en = i_wdata[0];
		end
		if (i_rd)
		begin
			if (i_addr == ADDR_LOCK_CFG)
				s_d.rdata = 24'(s_q.lock_cfg);
			else if (i_addr == ADDR_GPO_CTRL)
				s_d.rdata = 24'(s_q.gpo_ctrl);
			else if (i_addr == ADDR_SLIP_CTRL)
				s_d.rdata = 24'(s_q.slip_ctrl);
			else if (i_addr == ADDR_RSVD_A)
				s_d.rdata = RST_RSVD_A;
			else if (i_addr == ADDR_TEMP_EN)
				s_d.rdata = 24'(s_q.temp_en);
			else if (i_addr == ADDR_STATUS)
				s_d.rdata = {18'h00000, sweep_active_flag, 1'b0,
					modulator_overflow_flags, locked_flag};
			else if (i_addr == ADDR_RSVD_B)
				s_d.rdata = RST_RSVD_B;
			else if (i_addr == ADDR_TEMP_RD)
				s_d.rdata = {17'h00000, temp_code};
			else if (i_addr == ADDR_RSVD_C)
				s_d.rdata = RST_RSVD_C;
			else
				s_d.rdata = 24'h000000;
		end
		// Force-route wins; the host must not read in that mode.
		if (s_q.lock_cfg[LCK_FORCE])
			s_d.sdo = locked_flag;
		else if (i_rd_busy)
			s_d.sdo = i_rd_bit;
		else if (s_q.lock_cfg[LCK_AUTO])
			s_d.sdo = locked_flag;
		else
			s_d.sdo = 1'b0;
		s_d.gp = route;
		// Pin c is bit 2 of the disable field, pin a bit 0.
		s_d.oe = {3{s_q.gpo_ctrl[GPO_DRV_EN]}} & ~s_q.gpo_ctrl[GPO_DIS_LO +: 3];
		s_d.step    = s_q.slip_ctrl[SLP_STEP_LO +: 4];
		s_d.slip_en = s_q.slip_ctrl[SLP_MANUAL]
			&& (s_q.slip_ctrl[SLP_STEP_LO +: 4] != 4'h0);
		s_d.det_rst_n = s_q.slip_ctrl[SLP_FORCE] ? s_q.slip_ctrl[SLP_MANUAL]
			: i_slip_reset_auto;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_q           <= '0;
			s_q.lock_cfg  <= RST_LOCK_CFG[LCK_WIDTH-1:0];
			s_q.gpo_ctrl  <= RST_GPO_CTRL[GPO_WIDTH-1:0];
			s_q.slip_ctrl <= RST_SLIP_CTRL[SLP_WIDTH-1:0];
			s_q.temp_en   <= RST_TEMP_EN[0];
			s_q.det_rst_n <= 1'b1;
		end
		else if (i_ce)
			s_q <= s_d;
	end

	assign o_rdata                = s_q.rdata;
	assign o_sdo                  = s_q.sdo;
	assign o_gp_out_pin_a         = s_q.gp[0];
	assign o_gp_out_pin_b         = s_q.gp[1];
	assign o_gp_out_pin_c         = s_q.gp[2];
	assign o_gp_out_pin_a_oe      = s_q.oe[0];
	assign o_gp_out_pin_b_oe      = s_q.oe[1];
	assign o_gp_out_pin_c_oe      = s_q.oe[2];
	assign o_slip_correction_step = s_q.step;
	assign o_slip_prevention_en   = s_q.slip_en;
	assign o_detector_reset_n     = s_q.det_rst_n;
	assign o_temp_sensor_en       = s_q.temp_en;

	chk_force_route_sdo: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.lock_cfg[LCK_FORCE]) |=> o_sdo == $past(locked_flag))
		else $error("forced route not showing lock");
	chk_auto_route_sdo: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !s_q.lock_cfg[LCK_FORCE] && s_q.lock_cfg[LCK_AUTO] && !i_rd_busy)
		|=> o_sdo == $past(locked_flag))
		else $error("auto route not showing lock");
	chk_static_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && gpo_sel == SEL_STATIC) |=> s_q.gp == $past(s_q.gpo_ctrl[GPO_DAT_LO +: 3]))
		else $error("static value not on pins");
	chk_reserved_sel_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && (gpo_sel == 4'h5 || gpo_sel == 4'h9 || gpo_sel > 4'ha)) |=> s_q.gp == 3'h0)
		else $error("reserved selector drives pins");
	chk_driver_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !s_q.gpo_ctrl[GPO_DRV_EN]) |=> s_q.oe == 3'h0)
		else $error("pins driven while drivers off");
	chk_slip_reset_manual: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.slip_ctrl[SLP_FORCE])
		|=> o_detector_reset_n == $past(s_q.slip_ctrl[SLP_MANUAL]))
		else $error("manual detector reset ignored");
	chk_slip_zero_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_q.slip_ctrl[SLP_STEP_LO +: 4] == 4'h0) |=> !o_slip_prevention_en)
		else $error("slip prevention on with zero step");
	chk_status_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_rd && i_addr == ADDR_STATUS) |=> o_rdata[0] == $past(locked_flag))
		else $error("status lock bit wrong");
	chk_reserved_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_rd && i_addr == ADDR_RSVD_B) |=> o_rdata == RST_RSVD_B)
		else $error("reserved register read wrong");
endmodule : plgs_regs

// ===== include/plgs_pkg.sv
/*
 * Package for the lock-detect, output-pin and status register bank.
 * Assumes a register port of 6-bit address and 24-bit data in the core clock domain.
 */
package plgs_pkg;
	localparam logic [5:0]  ADDR_LOCK_CFG   = 6'h1a;
	localparam logic [5:0]  ADDR_GPO_CTRL   = 6'h1b;
	localparam logic [5:0]  ADDR_SLIP_CTRL  = 6'h1c;
	localparam logic [5:0]  ADDR_RSVD_A     = 6'h1d;
	localparam logic [5:0]  ADDR_TEMP_EN    = 6'h1e;
	localparam logic [5:0]  ADDR_STATUS     = 6'h1f;
	localparam logic [5:0]  ADDR_RSVD_B     = 6'h20;
	localparam logic [5:0]  ADDR_TEMP_RD    = 6'h21;
	localparam logic [5:0]  ADDR_RSVD_C     = 6'h22;
	localparam logic [23:0] RST_LOCK_CFG    = 24'h001040;
	localparam logic [23:0] RST_GPO_CTRL    = 24'h000000;
	localparam logic [23:0] RST_SLIP_CTRL   = 24'h000020;
	localparam logic [23:0] RST_TEMP_EN     = 24'h000000;
	localparam logic [23:0] RST_RSVD_A      = 24'h000000;
	localparam logic [23:0] RST_RSVD_B      = 24'h000020;
	localparam logic [23:0] RST_RSVD_C      = 24'h000000;
	localparam logic [6:0]  RST_TEMP_CODE   = 7'h1f;
	localparam logic [6:0]  TEMP_CODE_MAX   = 7'h07;
	// Lock-config fields.
	localparam int LCK_THR_MSB = 9;
	localparam int LCK_ASYM    = 10;
	localparam int LCK_ASYM_UP = 11;
	localparam int LCK_AUTO    = 12;
	localparam int LCK_FORCE   = 13;
	localparam int LCK_RING    = 14;
	localparam int LCK_RSPD_LO = 15;
	localparam int LCK_DUR_LO  = 17;
	localparam int LCK_WIDTH   = 20;
	// Output-control fields.
	localparam int GPO_SEL_LO  = 0;
	localparam int GPO_DAT_LO  = 4;
	localparam int GPO_DRV_EN  = 7;
	localparam int GPO_DIS_LO  = 8;
	localparam int GPO_WIDTH   = 11;
	// Slip-control fields.
	localparam int SLP_STEP_LO = 0;
	localparam int SLP_FORCE   = 4;
	localparam int SLP_MANUAL  = 5;
	localparam int SLP_WIDTH   = 6;
	// Nominal asymmetric window width and cycles at 20 MHz (rounded down, at least 1).
	localparam int ASYM_WIN_NS = 10;
	localparam int CLK_NS      = 50;
	localparam int ASYM_CYC    = (ASYM_WIN_NS / CLK_NS) < 1 ? 1 : (ASYM_WIN_NS / CLK_NS);
	// Base window lengths per duration code, one-shot sources.
	localparam int WIN_BASE    = 2;
	localparam logic [3:0] SEL_STATIC = 4'h0;
	localparam logic [3:0] SEL_PFD    = 4'h2;
	localparam logic [3:0] SEL_SAT    = 4'h3;
	localparam logic [3:0] SEL_XREF   = 4'h4;
	localparam logic [3:0] SEL_PHASE  = 4'h6;
	localparam logic [3:0] SEL_CLKS   = 4'h7;
	localparam logic [3:0] SEL_SWEEP  = 4'h8;
	localparam logic [3:0] SEL_QUANT  = 4'ha;
	typedef enum logic [1:0] {PLGS_IDLE, PLGS_WIN, PLGS_GAP} plgs_win_t;
endpackage : plgs_pkg

// ===== include/plgs_lock_if.sv
/*
 * Interface between the register bank and the lock detector.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
interface plgs_lock_if;
	logic [9:0] threshold;
	logic       asym_en;
	logic       asym_up;
	logic       ring_sel;
	logic [1:0] ring_speed;
	logic [1:0] duration;
	logic       ref_tick;
	logic       in_phase;
	logic       window;
	logic       locked;
	modport bank (output threshold, asym_en, asym_up, ring_sel, ring_speed, duration,
		ref_tick, in_phase, input window, locked);
	modport det (input threshold, asym_en, asym_up, ring_sel, ring_speed, duration,
		ref_tick, in_phase, output window, locked);
endinterface : plgs_lock_if

// ===== hw/plgs_lock_det.sv
/*
 * Lock detector: counts reference ticks with phase error inside the window.
 * Assumes ref_tick and in_phase are synchronised pulses in the core clock domain.
 */
`timescale 1ns/1ps
module plgs_lock_det
	import plgs_pkg::*;
(
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	// Bank side.
	plgs_lock_if.det  lk
);
	typedef struct packed {
		plgs_win_t  st;
		logic [4:0] tmr;
		logic [9:0] cnt;
		logic       locked;
	} plgs_det_t;
	plgs_det_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			PLGS_IDLE:
				if (lk.ref_tick)
				begin
					s_d.st = PLGS_WIN;
					// Ring one-shot scales with speed code, analog one with duration.
					if (lk.asym_en)
						s_d.tmr = 5'(ASYM_CYC);
					else if (lk.ring_sel)
						s_d.tmr = 5'(WIN_BASE + 2 * lk.ring_speed);
					else
						s_d.tmr = 5'(WIN_BASE + 2 * lk.duration);
					if (lk.in_phase ^ (lk.asym_en & lk.asym_up))
					begin
						if (s_q.cnt < lk.threshold)
							s_d.cnt = s_q.cnt + 10'h001;
					end
					else
					begin
						s_d.cnt    = '0;
						s_d.locked = 1'b0;
					end
				end
			PLGS_WIN:
				if (s_q.tmr <= 5'h01)
					s_d.st = PLGS_IDLE;
				else
					s_d.tmr = s_q.tmr - 5'h01;
			default:
				s_d.st = PLGS_IDLE;
		endcase
		if (s_d.cnt >= lk.threshold)
			s_d.locked = 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= '0;
		else if (i_ce)
			s_q <= s_d;
	end

	assign lk.window = (s_q.st == PLGS_WIN);
	assign lk.locked = s_q.locked;

	chk_lock_on_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && s_d.cnt >= lk.threshold) |=> s_q.locked)
		else $error("lock not declared at threshold");
endmodule : plgs_lock_det

// ===== hw/plgs_temp_conv.sv
/*
 * Temperature code converter: floor((T+40)/17.5) with saturation.
 * Assumes the sensor reports whole tenths of a degree plus 400 (T+40 in 0.1 C).
 */
`timescale 1ns/1ps
module plgs_temp_conv
	import plgs_pkg::*;
(
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	// Sensor.
	input  wire logic       i_en,
	input  wire logic [11:0] i_deci_offs,
	output logic [6:0]      o_code
);
	localparam logic [11:0] STEP_DECI = 12'd175;
	localparam logic [11:0] SAT_DECI  = STEP_DECI * 12'(TEMP_CODE_MAX);
	typedef struct packed { logic [6:0] code; } plgs_tc_t;
	plgs_tc_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		if (i_en)
		begin
			if (i_deci_offs >= SAT_DECI)
				s_d.code = TEMP_CODE_MAX;
			else
				s_d.code = 7'(i_deci_offs / STEP_DECI);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= '{code: RST_TEMP_CODE};
		else if (i_ce)
			s_q <= s_d;
	end

	assign o_code = s_q.code;

	chk_temp_saturate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_en && i_deci_offs >= SAT_DECI) |=> o_code == TEMP_CODE_MAX)
		else $error("temperature code not saturated");
endmodule : plgs_temp_conv

// ===== bench/plgs_host_model.sv
/*
 * Host controller model for the register bank: one-cycle write and read strobes and
 * the serial read path that borrows the data output pin.
 * Assumes one clock shared with the bank; every request changes 2 ns after a rising edge.
 */
`timescale 1ns/1ps
module plgs_host_model
(
	// Clock.
	input  wire logic        i_clk,
	// Register port.
	output logic             o_wr,
	output logic             o_rd,
	output logic [5:0]       o_addr,
	output logic [23:0]      o_wdata,
	input  wire logic [23:0] i_rdata,
	// Serial read path.
	output logic             o_rd_busy,
	output logic             o_rd_bit
);
	logic force_q;

	initial
	begin
		o_wr      = 1'b0;
		o_rd      = 1'b0;
		o_addr    = 6'h3f;
		o_wdata   = 24'h0;
		o_rd_busy = 1'b0;
		o_rd_bit  = 1'b0;
		force_q   = 1'b0;
	end

	// Released address and data lines show the inverse, so stale values never match.
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge i_clk);
		#2;
		o_wr    = 1'b1;
		o_addr  = a;
		o_wdata = d;
		if (a == 6'h1a)
			force_q = d[13];
		@(posedge i_clk);
		#2;
		o_wr    = 1'b0;
		o_addr  = ~a;
		o_wdata = ~d;
	endtask : wr

	// No read is issued while the lock indication owns the pin.
	task automatic rd(input logic [5:0] a, output logic [23:0] d);
		d = 24'h0;
		if (!force_q)
		begin
			@(posedge i_clk);
			#2;
			o_rd   = 1'b1;
			o_addr = a;
			@(posedge i_clk);
			#2;
			o_rd   = 1'b0;
			o_addr = ~a;
			@(posedge i_clk);
			#2;
			d = i_rdata;
		end
	endtask : rd

	task automatic serial(input logic b);
		@(posedge i_clk);
		#2;
		o_rd_busy = !force_q;
		o_rd_bit  = b;
	endtask : serial

	task automatic serial_end();
		@(posedge i_clk);
		#2;
		o_rd_busy = 1'b0;
		o_rd_bit  = ~o_rd_bit;
	endtask : serial_end
endmodule : plgs_host_model

// ===== bench/plgs_regs_tb_top.sv
/*
 * Self-checking bench for the register bank: reset values, pin routing, status, slip,
 * temperature and data-pin routing of the lock indication.
 * Assumes the host model is the only source of register traffic.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s expected %h seen %h", nm, e, g); \
		end \
	end
module plgs_regs_tb_top
	import plgs_pkg::*;
;
	typedef struct packed {logic [10:0] w; logic [2:0] pins; logic [2:0] mask;
		logic [2:0] oe;} plgs_row_t;
	typedef struct packed {logic [5:0] w; logic aut; logic [3:0] step; logic en;
		logic det;} plgs_slip_t;
	typedef struct packed {logic [11:0] deci; logic [6:0] code;} plgs_temp_t;
	localparam plgs_row_t ROWS [15] = '{'{11'h0d0, 3'h5, 3'h7, 3'h7}, '{11'h1a0, 3'h2, 3'h7, 3'h6},
		'{11'h282, 3'h4, 3'h6, 3'h5}, '{11'h483, 3'h3, 3'h7, 3'h3}, '{11'h084, 3'h5, 3'h7, 3'h7},
		'{11'h086, 3'h6, 3'h7, 3'h7}, '{11'h087, 3'h3, 3'h7, 3'h7}, '{11'h088, 3'h2, 3'h6, 3'h7},
		'{11'h08a, 3'h6, 3'h7, 3'h7}, '{11'h081, 3'h0, 3'h7, 3'h7}, '{11'h085, 3'h0, 3'h7, 3'h7},
		'{11'h089, 3'h0, 3'h7, 3'h7}, '{11'h08f, 3'h0, 3'h7, 3'h7}, '{11'h070, 3'h7, 3'h7, 3'h0},
		'{11'h7f0, 3'h7, 3'h7, 3'h0}};
	localparam plgs_slip_t SLIPS [5] = '{'{6'h25, 1'b1, 4'h5, 1'b1, 1'b1},
		'{6'h25, 1'b0, 4'h5, 1'b1, 1'b0}, '{6'h10, 1'b1, 4'h0, 1'b0, 1'b0},
		'{6'h30, 1'b0, 4'h0, 1'b0, 1'b1}, '{6'h2f, 1'b1, 4'hf, 1'b1, 1'b1}};
	localparam plgs_temp_t TEMPS [8] = '{'{12'h000, 7'h00}, '{12'h0ae, 7'h00}, '{12'h0af, 7'h01},
		'{12'h15d, 7'h01}, '{12'h15e, 7'h02}, '{12'h4c8, 7'h06}, '{12'h4c9, 7'h07}, '{12'h640, 7'h07}};
	// Status reads 0x2a at reset because sweep and overflow bits 3 and 1 are held high.
	localparam logic [23:0] RSTV [10] = '{24'h001040, 24'h0, 24'h000020, 24'h0, 24'h0,
		24'h00002a, 24'h000020, 24'h00001f, 24'h0, 24'h0};

	logic        clk;
	logic        rst_n;
	logic [14:0] an;
	logic [3:1]  qphase;
	logic [2:0]  quant;
	logic [3:1]  ovf;
	logic [11:0] temp;
	logic        wr, rd, rd_busy, rd_bit, sdo, pa, pb, pc, oa, ob, oc, slip_en, det_n, t_en;
	logic [5:0]  addr;
	logic [23:0] wdata, rdata, d;
	logic [3:0]  step;
	logic [2:0]  tcnt;
	logic        tick_on;
	logic        ce;
	logic [2:0]  pm;
	int          fail_count = 0;
	int          samples_checked = 0;

	plgs_host_model host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
		.i_rdata(rdata), .o_rd_busy(rd_busy), .o_rd_bit(rd_bit));

	plgs_regs uut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wr(wr), .i_rd(rd), .i_addr(addr),
		.i_wdata(wdata), .i_rd_busy(rd_busy), .i_rd_bit(rd_bit), .o_rdata(rdata), .o_sdo(sdo),
		.i_ref_tick(an[0]), .i_in_phase(an[1]), .i_pfd_up(an[2]), .i_detector_down_pulse(an[3]),
		.i_sat_ref(an[4]), .i_sat_div(an[5]), .i_gain_hold(an[6]), .i_aux_ref(an[7]),
		.i_aux_sine(an[8]), .i_synced_fraction_strobe(an[9]), .i_quantized_osc_phase(qphase),
		.i_aux_clk(an[10]), .i_ring_test(an[11]), .i_modulator_clock(an[12]),
		.i_sweep_busy(an[13]), .i_quant_out(quant), .i_mod_overflow(ovf), .i_temp_deci(temp),
		.i_slip_reset_auto(an[14]), .o_gp_out_pin_a(pa), .o_gp_out_pin_b(pb),
		.o_gp_out_pin_c(pc), .o_gp_out_pin_a_oe(oa), .o_gp_out_pin_b_oe(ob),
		.o_gp_out_pin_c_oe(oc), .o_slip_correction_step(step), .o_slip_prevention_en(slip_en),
		.o_detector_reset_n(det_n), .o_temp_sensor_en(t_en));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// One reference tick every eight cycles while enabled.
	always @(posedge clk)
	begin
		tcnt  <= tcnt + 3'h1;
		an[0] <= #2 tick_on && (tcnt == 3'h0);
	end

	task automatic give_verdict();
		$display("TB: comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : settle

	initial
	begin
		#1000000;
		fail_count++;
		$display("TB: run cut short by watchdog");
		give_verdict();
	end

	initial
	begin
		rst_n   = 1'b0;
		an      = 15'h7ae6;
		qphase  = 3'h3;
		quant   = 3'h6;
		ovf     = 3'h5;
		temp    = 12'h0;
		tick_on = 1'b0;
		ce      = 1'b1;
		tcnt    = 3'h0;
		settle(11);
		`CHK("oe in reset", 3'h0, {oc, ob, oa})
		`CHK("detector reset in reset", 1'b1, det_n)
		settle(1);
		rst_n = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			host.rd(6'h1a + 6'(i), d);
			`CHK("reset value", RSTV[i], d)
			if (i == 3 || i > 4)
			begin
				host.wr(6'h1a + 6'(i), 24'hffffff);
				host.rd(6'h1a + 6'(i), d);
				`CHK("after write", RSTV[i], d)
			end
		end
		$display("TB: reset and reserved test done");
		foreach (ROWS[i])
		begin
			host.wr(ADDR_GPO_CTRL, {13'h0, ROWS[i].w});
			settle(4);
			pm = ROWS[i].mask;
			`CHK("pins", ROWS[i].pins & pm, {pc, pb, pa} & pm)
			`CHK("oe", ROWS[i].oe, {oc, ob, oa})
			host.rd(ADDR_GPO_CTRL, d);
			`CHK("gpo readback", {13'h0, ROWS[i].w}, d)
		end
		// With the enable low a write must be dropped and the pins must hold.
		ce = 1'b0;
		host.wr(ADDR_GPO_CTRL, 24'h000080);
		settle(3);
		`CHK("oe frozen", 3'h0, {oc, ob, oa})
		ce = 1'b1;
		host.rd(ADDR_GPO_CTRL, d);
		`CHK("gpo after freeze", 24'h0007f0, d)
		$display("TB: pin routing test done");
		an[13] = 1'b0;
		ovf    = 3'h2;
		settle(5);
		host.rd(ADDR_STATUS, d);
		`CHK("status", 24'h000004, d & 24'h00002e)
		foreach (SLIPS[i])
		begin
			an[14] = SLIPS[i].aut;
			host.wr(ADDR_SLIP_CTRL, {18'h0, SLIPS[i].w});
			settle(4);
			`CHK("slip step", SLIPS[i].step, step)
			`CHK("slip enable", SLIPS[i].en, slip_en)
			`CHK("detector reset", SLIPS[i].det, det_n)
		end
		$display("TB: slip test done");
		host.wr(ADDR_TEMP_EN, 24'h000001);
		foreach (TEMPS[i])
		begin
			temp = TEMPS[i].deci;
			d    = 24'hffffff;
			for (int k = 0; k < 20 && d !== {17'h0, TEMPS[i].code}; k++)
				host.rd(ADDR_TEMP_RD, d);
			`CHK("temp code", {17'h0, TEMPS[i].code}, d)
		end
		`CHK("temp enable", 1'b1, t_en)
		$display("TB: temperature test done");
		host.wr(ADDR_LOCK_CFG, 24'h001004);
		tick_on = 1'b1;
		d       = 24'h0;
		for (int k = 0; k < 40 && d[0] !== 1'b1; k++)
			host.rd(ADDR_STATUS, d);
		`CHK("locked", 1'b1, d[0])
		settle(2);
		`CHK("sdo auto", 1'b1, sdo)
		host.serial(1'b0);
		settle(2);
		`CHK("sdo read bit", 1'b0, sdo)
		host.serial_end();
		settle(2);
		`CHK("sdo after read", 1'b1, sdo)
		host.wr(ADDR_LOCK_CFG, 24'h002004);
		settle(3);
		`CHK("sdo forced", 1'b1, sdo)
		host.wr(ADDR_LOCK_CFG, 24'h000004);
		settle(3);
		`CHK("sdo unrouted", 1'b0, sdo)
		// Asymmetric window with the up polarity treats the in-phase input as a miss.
		host.wr(ADDR_LOCK_CFG, 24'h000c04);
		settle(20);
		host.rd(ADDR_STATUS, d);
		`CHK("asym unlock", 1'b0, d[0])
		$display("TB: data pin test done");
		rst_n = 1'b0;
		settle(2);
		`CHK("oe mid reset", 3'h0, {oc, ob, oa})
		rst_n = 1'b1;
		host.rd(ADDR_LOCK_CFG, d);
		`CHK("lock cfg after reset", 24'h001040, d)
		host.rd(ADDR_GPO_CTRL, d);
		`CHK("gpo after reset", 24'h0, d)
		$display("TB: second reset test done");
		give_verdict();
	end
endmodule : plgs_regs_tb_top
